// ==== pkg/nalu_pkg.sv ====
// nalu_pkg: opcode, field and timing constants for the nibble alu
// assumes: 10-bit instruction words, 4-bit data, page-wide table reads
package nalu_pkg;
   // operation codes decoded from the instruction word
   typedef enum logic [4:0]
   {
      NALU_OP_NONE  = 5'h00,
      NALU_OP_LDI   = 5'h01,
      NALU_OP_TBL   = 5'h02,
      NALU_OP_ADDM  = 5'h03,
      NALU_OP_ADCM  = 5'h04,
      NALU_OP_ADDI  = 5'h05,
      NALU_OP_ANDM  = 5'h06,
      NALU_OP_ORM   = 5'h07,
      NALU_OP_SETC  = 5'h08,
      NALU_OP_CLRC  = 5'h09,
      NALU_OP_TSTC  = 5'h0A,
      NALU_OP_CPL   = 5'h0B,
      NALU_OP_ROR   = 5'h0C,
      NALU_OP_BSET  = 5'h0D,
      NALU_OP_BCLR  = 5'h0E,
      NALU_OP_BTST  = 5'h0F,
      NALU_OP_CMPM  = 5'h10,
      NALU_OP_CMPI  = 5'h11
   } nalu_op_t;

   // table-read state machine, one-hot
   typedef enum logic [2:0]
   {
      NALU_ST_EXEC = 3'b001,
      NALU_ST_TREQ = 3'b010,
      NALU_ST_TDAT = 3'b100
   } nalu_state_t;

   localparam int unsigned NALU_IW    = 10;
   localparam int unsigned NALU_DW    = 4;
   localparam int unsigned NALU_PW    = 5;
   localparam int unsigned NALU_RAW   = 12;
   localparam int unsigned NALU_IMM_LO = 0;
   localparam int unsigned NALU_SEL_LO = 0;
   localparam logic [3:0] NALU_A_RST  = 4'h0;
   localparam logic [3:0] NALU_B_RST  = 4'h0;
   localparam logic [2:0] NALU_D_RST  = 3'h0;
   localparam logic       NALU_CY_RST = 1'b0;
   localparam logic [4:0] NALU_PG_RST = 5'h00;
   // table read holds one return-stack level for this many nanoseconds
   localparam int unsigned NALU_TBL_NS    = 20;
   localparam int unsigned NALU_CLK_NS    = 10;
   localparam int unsigned NALU_TBL_CYC   =
      (NALU_TBL_NS + NALU_CLK_NS - 1) / NALU_CLK_NS;
   localparam int unsigned NALU_MEM_WORDS = 256;
   localparam int unsigned NALU_MAW       = 8;
endpackage

// ==== design/nalu_decode.sv ====
// nalu_decode: maps an instruction word to an operation code
// assumes: word is stable while valid; encodings follow the core's map
`timescale 1ns/100ps
`default_nettype none
module nalu_decode
(
   input  wire logic [9:0]        instr,
   output nalu_pkg::nalu_op_t     op
);
   import nalu_pkg::*;

   // fixed encodings and immediate-field groups
   wire is_ldi  = (instr[9:4] == 6'h07);
   // table, add and compare groups kept apart from the load group
   wire is_tbl  = (instr[9:5] == 5'h04);
   wire is_addi = (instr[9:4] == 6'h06);
   wire is_cmpi = (instr[9:4] == 6'h03);
   wire is_bset = (instr[9:2] == 8'h17);
   wire is_bclr = (instr[9:2] == 8'h13);
   wire is_btst = (instr[9:2] == 8'h08);

   always_comb
   begin
      op = NALU_OP_NONE;
      if (is_ldi) op = NALU_OP_LDI;
      else if (is_tbl) op = NALU_OP_TBL;
      else if (is_addi) op = NALU_OP_ADDI;
      else if (is_bset) op = NALU_OP_BSET;
      else if (is_bclr) op = NALU_OP_BCLR;
      else if (is_btst) op = NALU_OP_BTST;
      else if (is_cmpi) op = NALU_OP_CMPI;
      else
      begin
         unique case (instr)
            10'h00A: op = NALU_OP_ADDM;
            10'h00B: op = NALU_OP_ADCM;
            10'h018: op = NALU_OP_ANDM;
            10'h019: op = NALU_OP_ORM;
            10'h007: op = NALU_OP_SETC;
            10'h006: op = NALU_OP_CLRC;
            10'h02F: op = NALU_OP_TSTC;
            10'h01C: op = NALU_OP_CPL;
            10'h01D: op = NALU_OP_ROR;
            10'h026: op = NALU_OP_CMPM;
            default: op = NALU_OP_NONE;
         endcase
      end
   end
endmodule
`default_nettype wire

// ==== design/nalu_mem.sv ====
// nalu_mem: 256 x 4 data memory with registered read data
// assumes: one address shared by read and write, write data wins on a write
`timescale 1ns/100ps
`default_nettype none
module nalu_mem
(
   input  wire logic       clk,
   input  wire logic       ce,
   input  wire logic [7:0] addr,
   input  wire logic       we,
   input  wire logic [3:0] wdata,
   output logic [3:0]      rdata
);
   import nalu_pkg::*;

   logic [3:0] mem [0:NALU_MEM_WORDS-1];

   // write then registered read
   always_ff @(posedge clk)
   begin
      if (ce)
      begin
         if (we) mem[addr] <= wdata;
         rdata <= we ? wdata : mem[addr];
      end
   end
endmodule
`default_nettype wire

// ==== design/nalu_core.sv ====
// nalu_core: executes transfer, arithmetic, logic, bit and compare ops
// assumes: instr_valid pulses once per fetched word; memory read is one
// cycle, so each instruction spends a read cycle then an execute cycle
`timescale 1ns/100ps
`default_nettype none
module nalu_core
(
   input  wire logic                clk,
   input  wire logic                rst,
   input  wire logic                ce,
   input  wire logic [9:0]          instr,
   input  wire logic                instr_valid,
   output logic                     instr_ready,
   input  wire logic [7:0]          data_pointer,
   input  wire logic [4:0]          page,
   input  wire logic                table_high_bits_flag,
   output logic [11:0]              rom_addr,
   output logic                     rom_req,
   input  wire logic [9:0]          rom_data,
   output logic                     return_stack_hold,
   output logic [3:0]               acc,
   output logic [3:0]               reg_b,
   output logic [2:0]               index_reg,
   output logic                     carry_flag,
   output logic                     skip_next,
   output logic                     busy
);
   import nalu_pkg::*;

   //**********************************************************
   // decode and memory
   //**********************************************************
   nalu_op_t    op_w;
   nalu_op_t    op_q;
   logic [9:0]  ir_q;
   logic        phase_q;
   logic [3:0]  mem_rd;
   logic        mem_we;
   logic [3:0]  mem_wd;

   nalu_decode u_dec
   (
      .instr (instr),
      .op    (op_w)
   );

   nalu_mem u_mem
   (
      .clk   (clk),
      .ce    (ce),
      .addr  (data_pointer),
      .we    (mem_we),
      .wdata (mem_wd),
      .rdata (mem_rd)
   );

   //**********************************************************
   // state
   //**********************************************************
   nalu_state_t state_q;
   nalu_state_t state_d;
   logic [3:0]  a_q, a_d;
   logic [3:0]  b_q, b_d;
   logic [2:0]  d_q, d_d;
   logic        cy_q, cy_d;
   logic        skip_q, skip_d;
   logic        last_ldi_q, last_ldi_d;
   logic        phase_d;
   logic [9:0]  rom_q;

   // immediate load test, shared by chain detect and chain record
   function automatic logic is_load(input nalu_op_t o);
      is_load = (o == NALU_OP_LDI);
   endfunction

   // field extraction
   wire [3:0] imm4    = ir_q[3:0];
   wire [1:0] sel2    = ir_q[1:0];
   wire [3:0] bit_msk = 4'h1 << sel2;
   wire       bit_val = |(mem_rd & bit_msk);
   wire [4:0] sum_m   = {1'b0, a_q} + {1'b0, mem_rd};
   wire [4:0] sum_mc  = {1'b0, a_q} + {1'b0, mem_rd} + {4'h0, cy_q};
   wire [4:0] sum_i   = {1'b0, a_q} + {1'b0, imm4};

   // a new word is taken only in the execute state, second phase done
   wire take  = instr_valid && (state_q == NALU_ST_EXEC) && !phase_q;
   // run phase: the cycle after take, memory data now valid
   wire run   = phase_q && (state_q == NALU_ST_EXEC);
   // a skipped word: pending skip or a repeated immediate load
   wire squash = skip_q || (last_ldi_q && is_load(op_q));

   // handshake and register views on the ports
   assign instr_ready = take;
   assign rom_req     = (state_q == NALU_ST_TREQ);
   assign rom_addr    = {page, d_q, a_q};
   assign return_stack_hold = (state_q != NALU_ST_EXEC);
   assign busy        = phase_q || (state_q != NALU_ST_EXEC);
   assign acc         = a_q;
   assign reg_b       = b_q;
   assign index_reg   = d_q;
   assign carry_flag  = cy_q;
   assign skip_next   = skip_q;

   // memory write for bit set and clear, blocked when skipped
   assign mem_we = ce && run && !squash &&
                   (op_q == NALU_OP_BSET || op_q == NALU_OP_BCLR);
   assign mem_wd = (op_q == NALU_OP_BSET) ? (mem_rd | bit_msk)
                                          : (mem_rd & ~bit_msk);

   // execute and table state machine
   always_comb
   begin
      state_d    = state_q;
      phase_d    = phase_q;
      a_d        = a_q;
      b_d        = b_q;
      d_d        = d_q;
      cy_d       = cy_q;
      skip_d     = skip_q;
      last_ldi_d = last_ldi_q;
      unique case (state_q)
         NALU_ST_EXEC:
         begin
            if (take) phase_d = 1'b1;
            if (run)
            begin
               phase_d    = 1'b0;
               skip_d     = 1'b0;
               last_ldi_d = is_load(op_q);
               if (!squash)
               begin
                  unique case (op_q)
                     NALU_OP_LDI:  a_d = imm4;
                     NALU_OP_TBL:  state_d = NALU_ST_TREQ;
                     NALU_OP_ADDM: a_d = sum_m[3:0];
                     NALU_OP_ADCM:
                     begin
                        a_d  = sum_mc[3:0];
                        cy_d = sum_mc[4];
                     end
                     NALU_OP_ADDI:
                     begin
                        a_d    = sum_i[3:0];
                        skip_d = !sum_i[4];
                     end
                     NALU_OP_ANDM: a_d = a_q & mem_rd;
                     NALU_OP_ORM:  a_d = a_q | mem_rd;
                     NALU_OP_SETC: cy_d = 1'b1;
                     NALU_OP_CLRC: cy_d = 1'b0;
                     NALU_OP_TSTC: skip_d = !cy_q;
                     NALU_OP_CPL:  a_d = ~a_q;
                     NALU_OP_ROR:
                     begin
                        a_d  = {cy_q, a_q[3:1]};
                        cy_d = a_q[0];
                     end
                     NALU_OP_BTST: skip_d = !bit_val;
                     NALU_OP_CMPM: skip_d = (a_q == mem_rd);
                     NALU_OP_CMPI: skip_d = (a_q == imm4);
                     default: ;
                  endcase
               end
            end
         end
         NALU_ST_TREQ: state_d = NALU_ST_TDAT;
         NALU_ST_TDAT:
         begin
            state_d = NALU_ST_EXEC;
            b_d     = rom_q[7:4];
            a_d     = rom_q[3:0];
            if (table_high_bits_flag)
               d_d = {1'b0, rom_q[9:8]};
         end
         default: state_d = NALU_ST_EXEC;
      endcase
   end

   // latch the taken word
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         ir_q <= 10'h000;
         op_q <= NALU_OP_NONE;
      end
      else if (ce && take)
      begin
         ir_q <= instr;
         op_q <= op_w;
      end
   end

   // rom data captured one cycle after request
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst) rom_q <= 10'h000;
      else if (ce && rom_req) rom_q <= rom_data;
   end

   // architectural registers
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         state_q    <= NALU_ST_EXEC;
         phase_q    <= 1'b0;
         a_q        <= NALU_A_RST;
         b_q        <= NALU_B_RST;
         d_q        <= NALU_D_RST;
         cy_q       <= NALU_CY_RST;
         skip_q     <= 1'b0;
         last_ldi_q <= 1'b0;
      end
      else if (ce)
      begin
         state_q    <= state_d;
         phase_q    <= phase_d;
         a_q        <= a_d;
         b_q        <= b_d;
         d_q        <= d_d;
         cy_q       <= cy_d;
         skip_q     <= skip_d;
         last_ldi_q <= last_ldi_d;
      end
   end
endmodule
`default_nettype wire

// ==== sim/nalu_core_assertions.sv ====
// nalu_checker: timing and result checks on nalu_core ports
// assumes: bound to nalu_core; opcode words follow the core's map
`timescale 1ns/100ps
`default_nettype none
module nalu_checker
(
   input wire logic        clk,
   input wire logic        rst,
   input wire logic        ce,
   input wire logic [9:0]  instr,
   input wire logic        instr_valid,
   input wire logic        instr_ready,
   input wire logic [4:0]  page,
   input wire logic        table_high_bits_flag,
   input wire logic [11:0] rom_addr,
   input wire logic        rom_req,
   input wire logic [9:0]  rom_data,
   input wire logic        return_stack_hold,
   input wire logic [3:0]  acc,
   input wire logic [3:0]  reg_b,
   input wire logic [2:0]  index_reg,
   input wire logic        carry_flag,
   input wire logic        skip_next
);
   // ****************************************
   // opcode words and taken-word decode
   // ****************************************
   localparam logic [9:0] K_RC  = 10'h006;
   localparam logic [9:0] K_SC  = 10'h007;
   localparam logic [9:0] K_CPL = 10'h01C;
   localparam logic [9:0] K_ROR = 10'h01D;
   localparam logic [9:0] K_TC  = 10'h02F;
   wire logic take;
   // word taken and not cancelled by a pending skip
   assign take = instr_valid & instr_ready & ce & ~skip_next;
   default clocking @(posedge clk); endclocking
   default disable iff (rst);
   property p_cpl;
      take && instr == K_CPL |=> ##1 acc == ~$past(acc, 2);
   endproperty
   a_cpl: assert property (p_cpl) else $error("complement wrong");
   property p_ror;
      take && instr == K_ROR |=> ##1
         {acc, carry_flag} == {$past(carry_flag, 2), $past(acc, 2)};
   endproperty
   a_ror: assert property (p_ror) else $error("rotate wrong");
   property p_sc;
      take && instr == K_SC |=> ##1 carry_flag && acc == $past(acc, 2);
   endproperty
   a_sc: assert property (p_sc) else $error("set carry wrong");
   property p_rc;
      take && instr == K_RC |=> ##1 !carry_flag && acc == $past(acc, 2);
   endproperty
   a_rc: assert property (p_rc) else $error("clear carry wrong");
   property p_tc;
      take && instr == K_TC |=> ##1 skip_next == !$past(carry_flag, 2);
   endproperty
   a_tc: assert property (p_tc) else $error("carry test wrong");
   property p_tbl;
      rom_req |-> ##2 {reg_b, acc} == $past(rom_data[7:0], 2);
   endproperty
   a_tbl: assert property (p_tbl) else $error("table load wrong");
   property p_tbhi;
      rom_req && table_high_bits_flag |-> ##2
         index_reg == {1'b0, $past(rom_data[9:8], 2)};
   endproperty
   a_tbhi: assert property (p_tbhi) else $error("index load wrong");
   property p_radr;
      rom_req |-> rom_addr == {page, index_reg, acc};
   endproperty
   a_radr: assert property (p_radr) else $error("rom address wrong");
   property p_hold;
      $rose(return_stack_hold) |-> ##1 return_stack_hold ##1 !return_stack_hold;
   endproperty
   a_hold: assert property (p_hold) else $error("stack hold wrong");
   c_tbl: cover property (rom_req && table_high_bits_flag);
   c_skip: cover property ($rose(skip_next));
   c_ror: cover property (take && instr == K_ROR);
endmodule
bind nalu_core nalu_checker u_chk (.clk, .rst, .ce, .instr, .instr_valid,
   .instr_ready, .page, .table_high_bits_flag, .rom_addr, .rom_req,
   .rom_data, .return_stack_hold, .acc, .reg_b, .index_reg, .carry_flag,
   .skip_next);
`default_nettype wire

// ==== sim/nibble_alu_skip_ops_test.sv ====
// nibble_alu_skip_ops_test: self-checking bench for nalu_core
// assumes: opcode words follow the core's map; memory starts unknown
`timescale 1ns/100ps
`default_nettype none
module nibble_alu_skip_ops_test;
   typedef struct packed
   {
      logic [9:0] w;
      logic [3:0] a;
      logic       c;
      logic       s;
   } nalu_row_t;
   logic        clk, rst, ce, instr_valid, instr_ready, table_high_bits_flag;
   logic        rom_req, return_stack_hold, carry_flag, skip_next, busy;
   logic [9:0]  instr, rom_data;
   logic [7:0]  data_pointer;
   logic [4:0]  page;
   logic [11:0] rom_addr, ra;
   logic [3:0]  acc, reg_b, hc;
   logic [2:0]  index_reg;
   int          n_errors, n_tests;
   // word, acc, carry, skip (x: not checked)
   nalu_row_t   rows [36] = '{
      {10'h075,4'h5,2'b0x}, {10'h079,4'h5,2'b0x}, {10'h07A,4'h5,2'b0x},
      {10'h01C,4'hA,2'b00}, {10'h007,4'hA,2'b10}, {10'h01D,4'hD,2'b00},
      {10'h02F,4'hD,2'b01}, {10'h01C,4'hD,2'b00}, {10'h04C,4'hD,2'b00},
      {10'h04D,4'hD,2'b00}, {10'h04E,4'hD,2'b00}, {10'h04F,4'hD,2'b00},
      {10'h05D,4'hD,2'b00}, {10'h020,4'hD,2'b01}, {10'h007,4'hD,2'b00},
      {10'h021,4'hD,2'b00}, {10'h072,4'h2,2'b0x}, {10'h026,4'h2,2'b01},
      {10'h01C,4'h2,2'b00}, {10'h01C,4'hD,2'b00}, {10'h026,4'hD,2'b00},
      {10'h019,4'hF,2'b00}, {10'h018,4'h2,2'b00}, {10'h007,4'h2,2'b10},
      {10'h00A,4'h4,2'b10}, {10'h00B,4'h7,2'b00}, {10'h07F,4'hF,2'b0x},
      {10'h00B,4'h1,2'b10}, {10'h02F,4'h1,2'b10}, {10'h006,4'h1,2'b00},
      {10'h06E,4'hF,2'b01}, {10'h007,4'hF,2'b00}, {10'h063,4'h2,2'b00},
      {10'h032,4'h2,2'b01}, {10'h01C,4'h2,2'b00}, {10'h035,4'h2,2'b00}};
   nalu_core DUT (.clk, .rst, .ce, .instr, .instr_valid, .instr_ready,
      .data_pointer, .page, .table_high_bits_flag, .rom_addr, .rom_req,
      .rom_data, .return_stack_hold, .acc, .reg_b, .index_reg, .carry_flag,
      .skip_next, .busy);
   // ****************************************
   // clock, table-read monitor, tasks
   // ****************************************
   initial
   begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   // capture rom address and count stack-hold cycles
   always @(posedge clk)
   begin
      if (rom_req === 1'b1) ra <= rom_addr;
      if (return_stack_hold === 1'b1) hc <= hc + 4'h1;
   end
   task automatic close_out();
      $display("tests %0d mismatches %0d", n_tests, n_errors);
      if (n_errors == 0 && n_tests > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask
   task automatic chk(input logic [11:0] g, input logic [11:0] e);
      n_tests++;
      if (g !== e)
      begin
         n_errors++;
         $display("FAIL t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask
   // offer one word, wait for it to finish, bounded
   task automatic run(input logic [9:0] w);
      int   k;
      logic taken;
      @(posedge clk);
      instr <= w;
      instr_valid <= 1'b1;
      k = 0;
      taken = 1'b0;
      do
      begin
         @(posedge clk);
         taken = (instr_ready === 1'b1);
         k++;
      end
      while (!taken && k < 20);
      instr_valid <= 1'b0;
      do
      begin
         @(posedge clk);
         #1;
         k++;
      end
      while (busy !== 1'b0 && k < 40);
      if (!taken || busy !== 1'b0)
      begin
         n_errors++;
         close_out();
      end
   endtask
   // ****************************************
   // main sequence
   // ****************************************
   initial
   begin
      {rst, ce, instr_valid, instr, rom_data} = {2'b11, 1'b0, 20'h0};
      {data_pointer, page, table_high_bits_flag, hc} = {8'h3C, 10'h0};
      repeat (2) @(posedge clk);
      rst <= 1'b0;
      foreach (rows[i])
      begin
         run(rows[i].w);
         chk(acc, rows[i].a);
         chk(carry_flag, rows[i].c);
         if (rows[i].s !== 1'bx)
            chk(skip_next, rows[i].s);
      end
      $display("table of words done");
      @(posedge clk);
      {page, table_high_bits_flag, rom_data} <= {5'h0A, 1'b1, 10'h2A5};
      run(10'h080);
      chk(ra, 12'h502);
      chk({reg_b, acc, 1'b0, index_reg}, 12'hA52);
      @(posedge clk);
      {table_high_bits_flag, rom_data} <= {1'b0, 10'h1C3};
      run(10'h080);
      chk(ra, 12'h525);
      chk({reg_b, acc, 1'b0, index_reg}, 12'hC32);
      chk(hc, 4'h4);
      $display("table read done");
      // a load before reset must not chain into a load after it
      run(10'h079);
      @(posedge clk);
      rst <= 1'b1;
      @(posedge clk);
      #1;
      chk({reg_b, acc, index_reg, carry_flag}, 12'h000);
      chk(skip_next, 12'h000);
      @(posedge clk);
      rst <= 1'b0;
      run(10'h07A);
      chk(acc, 12'h00A);
      $display("reset done");
      // clock enable low: an offered complement changes nothing
      @(posedge clk);
      ce <= 1'b0;
      instr <= 10'h01C;
      instr_valid <= 1'b1;
      repeat (3) @(posedge clk);
      #1;
      chk({busy, acc}, 12'h00A);
      @(posedge clk);
      {ce, instr_valid} <= 2'b10;
      $display("clock enable done");
      close_out();
   end
endmodule
`default_nettype wire
